// *** hw/bit_fifo.sv ***
// Small flop-based FIFO used between the phase aligner and the realigner
`timescale 1ns/100ps
module bit_fifo
#(
	parameter int WIDTH = 1,
	parameter int DEPTH = 6
)
(
	input wire logic clock,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic push;
	logic pop;

	assign in_ready = count != (PW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Flush doubles as reset so one clear path serves every owner
	always_ff @(posedge clock)
	begin
		if (flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : bit_fifo

// *** hw/pin_sync.sv ***
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic d,
	output logic q
);
	logic s1;
	logic s2;
	logic s3;

	// Only the second stage reads the first; q follows when the last two agree
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q <= s3;
		end
	end
endmodule : pin_sync

// *** hw/serial_rx_align_control.sv ***
// Serial receive channel: phase aligner, sync buffer, bit-slip realigner and register slave
// Summary of operation
// - Each rising slip request moves the word boundary by exactly one bit.
// - With freeze low the aligner follows phase drift of the incoming data.
// - With freeze high the aligner keeps its last locked sampling phase.
// - Freeze has no effect in the mode without phase alignment.
// - Parallel word is exactly deserialize_factor bits wide.
// - Words change only on the parallel clock enable in every mode.
// - PLL lock flag is high while the reference link clock is steadily present.
// - Initial phase lock flag marks the first lock only and stays set afterwards.
// - Rollover output pulses for one parallel cycle after the programmed slip count.
// - Recovered parallel clock toggles only in clock recovery mode.
// - Calibration request starts calibration without resetting aligner or lock.
// - Calibration busy stays high for the whole calibration.
// - Aligner reset clears both the phase aligner and the sync buffer.
// - Buffer reset clears only the sync buffer.
// - Realign reset clears the realigner including its slip position.
// - All reset and control bits are active high.
// - Every control works per channel in all three receive modes, except freeze, which has no effect in the non-aligned mode.
// - Sync buffer is one bit wide and six entries deep.
// - At most ten parallel bits per channel.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module serial_rx_align_control
	import serial_rx_pkg::*;
#(
	parameter int DESER_FACTOR = 10 // Ten bits at most per channel
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic link_clk,
	input wire logic rx_serial,
	output logic [DESER_FACTOR-1:0] rx_word,
	output logic word_valid,
	output logic slip_rollover,
	output logic rec_clk,
	output logic pll_locked,
	output logic dpa_locked,
	output logic cal_busy
);
	localparam int CW = $clog2(DESER_FACTOR);
	localparam logic [CW-1:0] last_bit = CW'(DESER_FACTOR - 1);
	localparam logic [CW-1:0] half_bit = CW'(DESER_FACTOR / 2);

	ctrl_t ctrl;
	config_t cfg;
	logic aw_full;
	logic w_full;
	logic [3:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	logic do_write;
	logic recal_req;
	logic link_s;
	logic link_d;
	logic ser_s;
	logic ser_d;
	logic link_rise;
	logic [2:0] phase_cnt;
	logic [2:0] phase_sel;
	logic [2:0] hit_phase;
	logic [2:0] hits;
	logic tracking;
	logic align_clr;
	logic realign_clr;
	logic fifo_flush;
	logic bit_v;
	logic bit_d;
	logic slip_q;
	logic slip_pend;
	logic slip_take;
	logic roll_hit;
	logic roll_pend;
	logic [7:0] slip_count;
	logic [CW-1:0] bit_cnt;
	logic [DESER_FACTOR-1:0] shift;
	logic [7:0] gap_cnt;
	logic [3:0] edge_cnt;
	logic [7:0] cal_cnt;

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	// Write channel: address and data are taken in either order, answer follows both
	assign s_awready = !aw_full && !s_bvalid;
	assign s_wready = !w_full && !s_bvalid;
	assign do_write = aw_full && w_full && !s_bvalid;
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_q <= 4'h0;
			w_q <= 32'h0;
			ws_q <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= resp_okay;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_full <= 1'b1;
				aw_q <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_full <= 1'b1;
				w_q <= s_wdata;
				ws_q <= s_wstrb;
			end
			if (do_write)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (aw_q == ctrl_addr || aw_q == config_addr) ? resp_okay : resp_slverr;
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	// Control and config storage; all control bits are active high
	assign recal_req = do_write && aw_q == ctrl_addr && ws_q[0] && w_q[recal_bit];
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			ctrl <= ctrl_reset;
			cfg <= config_reset;
		end
		else if (do_write && aw_q == ctrl_addr)
			ctrl <= ctrl_t'(w_q[ctrl_width-1:0] & {ctrl_width{ws_q[0]}} |
				ctrl & {ctrl_width{!ws_q[0]}});
		else if (do_write && aw_q == config_addr)
			cfg <= config_t'(16'(merge({16'h0, cfg}, w_q, ws_q) & 32'h0000ff03));
	end

	// Read channel: one cycle to answer, unmapped offsets give a slave error
	assign s_arready = !s_rvalid;
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
			s_rresp <= resp_okay;
		end
		else if (s_arvalid && s_arready)
		begin
			s_rvalid <= 1'b1;
			s_rresp <= resp_okay;
			unique case (s_araddr)
				ctrl_addr: s_rdata <= {27'h0, ctrl};
				config_addr: s_rdata <= {16'h0, cfg};
				status_addr: s_rdata <= {16'h0, slip_count, 1'b0, phase_sel, 1'b0, cal_busy,
					dpa_locked, pll_locked};
				word_addr: s_rdata <= 32'(rx_word);
				default:
				begin
					s_rdata <= 32'h0;
					s_rresp <= resp_slverr;
				end
			endcase
		end
		else if (s_rvalid && s_rready)
			s_rvalid <= 1'b0;
	end

	// Link clock and serial data come from the far side and are synchronised alike
	pin_sync link_sync (.clock(clock), .rst_b(rst_b), .d(link_clk), .q(link_s));
	pin_sync data_sync (.clock(clock), .rst_b(rst_b), .d(rx_serial), .q(ser_s));

	// Phase counter splits each link bit into eight sampling phases
	assign link_rise = link_s && !link_d;
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			link_d <= 1'b0;
			ser_d <= 1'b0;
			phase_cnt <= 3'h0;
		end
		else
		begin
			link_d <= link_s;
			ser_d <= ser_s;
			phase_cnt <= link_rise ? 3'h0 : phase_cnt + 3'h1;
		end
	end

	// Aligner keeps the sampling point opposite the data transitions
	assign tracking = cfg.mode == mode_phase_aligned || cfg.mode == mode_clock_recovery;
	assign align_clr = !rst_b || ctrl.align_rst;
	always_ff @(posedge clock)
	begin
		if (align_clr)
		begin
			phase_sel <= phase_mid;
			hit_phase <= 3'h0;
			hits <= 3'h0;
			dpa_locked <= 1'b0;
		end
		else if (!tracking)
			phase_sel <= phase_mid;
		else if (ser_s != ser_d && !ctrl.freeze)
		begin
			phase_sel <= phase_cnt + phase_half;
			hit_phase <= phase_cnt;
			hits <= (phase_cnt != hit_phase) ? 3'h0 : (hits == lock_hits) ? hits : hits + 3'h1;
			// Sticky: a later phase change never drops it, only a reset does
			if (phase_cnt == hit_phase && hits == lock_hits - 3'h1)
				dpa_locked <= 1'b1;
		end
	end

	// One-bit six-deep buffer between aligner and realigner
	assign fifo_flush = align_clr || ctrl.fifo_rst;
	bit_fifo #(.WIDTH(1), .DEPTH(sync_depth)) sync_buf (
		.clock(clock),
		.flush(fifo_flush),
		.in_valid(phase_cnt == phase_sel),
		.in_ready(),
		.in_data(ser_s),
		.out_valid(bit_v),
		.out_ready(1'b1),
		.out_data(bit_d)
	);

	// Realigner: a slip lets one bit in without counting it
	assign realign_clr = !rst_b || ctrl.realign_rst;
	assign slip_take = bit_v && slip_pend;
	assign roll_hit = slip_take && slip_count == cfg.rollover - 8'h1;
	always_ff @(posedge clock)
	begin
		if (realign_clr)
		begin
			slip_q <= 1'b0;
			slip_pend <= 1'b0;
			slip_count <= 8'h0;
			bit_cnt <= '0;
			shift <= '0;
		end
		else
		begin
			slip_q <= ctrl.slip_req;
			// A new edge in the cycle a slip is taken is kept, not lost
			if (ctrl.slip_req && !slip_q)
				slip_pend <= 1'b1;
			else if (slip_take)
				slip_pend <= 1'b0;
			if (slip_take)
				slip_count <= roll_hit ? 8'h0 : slip_count + 8'h1;
			if (bit_v)
			begin
				shift <= {shift[DESER_FACTOR-2:0], bit_d};
				if (!slip_pend)
					bit_cnt <= (bit_cnt == last_bit) ? '0 : bit_cnt + 1'b1;
			end
		end
	end

	// Word output and rollover marker move only on the parallel clock enable
	always_ff @(posedge clock)
	begin
		if (realign_clr)
		begin
			// The last word stays readable through a realign reset; only a full reset clears it
			if (!rst_b)
				rx_word <= '0;
			word_valid <= 1'b0;
			roll_pend <= 1'b0;
			slip_rollover <= 1'b0;
		end
		else
		begin
			word_valid <= bit_v && !slip_pend && bit_cnt == last_bit;
			if (bit_v && !slip_pend && bit_cnt == last_bit)
			begin
				rx_word <= {shift[DESER_FACTOR-2:0], bit_d};
				slip_rollover <= roll_pend;
				roll_pend <= roll_hit;
			end
			else if (roll_hit)
				roll_pend <= 1'b1;
		end
	end

	// Recovered parallel clock: high for the first half of each word, recovery mode only
	always_ff @(posedge clock)
	begin
		if (realign_clr || cfg.mode != mode_clock_recovery)
			rec_clk <= 1'b0;
		else if (bit_v)
			rec_clk <= bit_cnt < half_bit;
	end

	// Link lock: a run of edges with no long gap counts as locked
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			gap_cnt <= 8'h0;
			edge_cnt <= 4'h0;
			pll_locked <= 1'b0;
		end
		else
		begin
			pll_locked <= edge_cnt == lock_edges;
			if (link_rise)
			begin
				gap_cnt <= 8'h0;
				if (edge_cnt != lock_edges)
					edge_cnt <= edge_cnt + 4'h1;
			end
			else if (gap_cnt == gap_cycles)
				edge_cnt <= 4'h0;
			else
				gap_cnt <= gap_cnt + 8'h1;
		end
	end

	// Calibration runs beside the aligner and touches no lock state
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			cal_cnt <= 8'h0;
		else if (recal_req && cal_cnt == 8'h0)
			cal_cnt <= cal_cycles;
		else if (cal_cnt != 8'h0)
			cal_cnt <= cal_cnt - 8'h1;
	end
	assign cal_busy = cal_cnt != 8'h0;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	slip_moves_a: assert property (slip_take && !ctrl.realign_rst |=> !word_valid)
		else $error("slip did not stall the boundary");
	track_follow_a: assert property (tracking && !ctrl.freeze && !ctrl.align_rst
		&& ser_s != ser_d |=> phase_sel == $past(phase_cnt) + phase_half)
		else $error("aligner did not follow transition");
	freeze_hold_a: assert property (ctrl.freeze && !ctrl.align_rst && tracking
		|=> $stable(phase_sel))
		else $error("phase moved while frozen");
	fixed_phase_a: assert property (!tracking |=> phase_sel == phase_mid)
		else $error("phase moved without alignment mode");
	word_timing_a: assert property ($changed(rx_word) |-> word_valid)
		else $error("word changed off the parallel enable");
	lock_gap_a: assert property (gap_cnt == gap_cycles && !link_rise |=> ##1 !pll_locked)
		else $error("lock kept through gap");
	lock_sticky_a: assert property (dpa_locked && !ctrl.align_rst |=> dpa_locked)
		else $error("initial lock dropped");
	roll_pulse_a: assert property ($changed(slip_rollover) && !$past(ctrl.realign_rst)
		|-> word_valid)
		else $error("rollover changed off the parallel enable");
	recov_clk_a: assert property (cfg.mode != mode_clock_recovery |=> !rec_clk)
		else $error("recovered clock outside recovery mode");
	cal_keep_a: assert property ($rose(cal_busy) && dpa_locked && !ctrl.align_rst
		|-> dpa_locked[*2])
		else $error("calibration disturbed lock");
	cal_busy_a: assert property ($rose(cal_busy) |-> cal_busy[*8])
		else $error("calibration busy too short");
	buf_reset_a: assert property (ctrl.fifo_rst |=> !bit_v)
		else $error("buffer not cleared");
	align_reset_a: assert property (ctrl.align_rst |=> !dpa_locked && !bit_v)
		else $error("aligner reset incomplete");
	realign_reset_a: assert property (ctrl.realign_rst
		|=> slip_count == 8'h0 && !slip_pend)
		else $error("realigner not cleared");
	roll_restart_a: assert property (roll_hit && !ctrl.realign_rst
		|=> slip_count == 8'h0)
		else $error("slip count did not restart");

	word_seen_c: cover property (word_valid);
	rollover_seen_c: cover property (slip_rollover);
	lock_seen_c: cover property ($rose(dpa_locked));
	cal_seen_c: cover property ($fell(cal_busy));
endmodule : serial_rx_align_control

// *** hw/serial_rx_pkg.sv ***
// Shared constants, register map and carrier types for the serial receive channel
package serial_rx_pkg;
	// Register byte offsets
	localparam logic [3:0] ctrl_addr = 4'h0;
	localparam logic [3:0] config_addr = 4'h4;
	localparam logic [3:0] status_addr = 4'h8;
	localparam logic [3:0] word_addr = 4'hc;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	// Control register layout; calibration request is a write-only strobe
	localparam int recal_bit = 5;
	localparam int ctrl_width = 5;
	localparam int config_width = 16;
	// Timing at the 25 MHz core clock
	localparam int clk_period_ns = 40;
	localparam int cal_time_ns = 2000;
	localparam int link_gap_ns = 1000;
	localparam logic [7:0] cal_cycles = 8'(cal_time_ns / clk_period_ns);
	localparam logic [7:0] gap_cycles = 8'((link_gap_ns + clk_period_ns - 1) / clk_period_ns);
	// Lock qualification and aligner geometry
	localparam logic [3:0] lock_edges = 4'h8;
	localparam logic [2:0] lock_hits = 3'h4;
	localparam logic [2:0] phase_mid = 3'h4;
	localparam logic [2:0] phase_half = 3'h4;
	localparam int sync_depth = 6;
	localparam logic [7:0] rollover_reset = 8'h0a;

	typedef enum logic [1:0] {
		mode_non_aligned = 2'b00,
		mode_phase_aligned = 2'b01,
		mode_clock_recovery = 2'b10
	} rx_mode_t;

	typedef struct packed {
		logic realign_rst;
		logic fifo_rst;
		logic align_rst;
		logic freeze;
		logic slip_req;
	} ctrl_t;

	typedef struct packed {
		logic [7:0] rollover;
		logic [5:0] pad;
		rx_mode_t mode;
	} config_t;

	localparam ctrl_t ctrl_reset = '0;
	localparam config_t config_reset = '{rollover: rollover_reset, pad: 6'h0,
		mode: mode_non_aligned};
endpackage : serial_rx_pkg

// *** tb/serial_tx_model.sv ***
// Remote serial transmitter model: repeats one word MSB first on a gated link clock
`timescale 1ns/100ps
module serial_tx_model
(
	input wire logic run,
	input wire logic [9:0] pattern,
	output logic link_clk,
	output logic rx_serial
);
	initial
	begin
		link_clk = 1'b0;
		rx_serial = 1'b0;
	end
	// Frames go back to back while run is high; the clock stands low between runs
	always
	begin
		wait (run);
		#3; // Offset keeps link edges off the core clock edges
		while (run)
		begin
			for (int i = 9; i >= 0; i--)
			begin
				rx_serial = pattern[i];
				#160 link_clk = 1'b1; // Active-high clock
				#160 link_clk = 1'b0;
			end
		end
		rx_serial = ~rx_serial; // A released line shows no stale bit
	end
endmodule : serial_tx_model

// *** tb/test_serial_rx_align_control.sv ***
// Register-level testbench for the serial receive channel
`timescale 1ns/100ps
module test_serial_rx_align_control;
	import serial_rx_pkg::*;
	localparam logic [9:0] pat = 10'h301;
	// One parallel period: ten link bits of 320 ns each
	localparam int word_cycles = 10 * 320 / clk_period_ns;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic [31:0] s_wdata = 32'h0, rd;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, run = 1'b0;
	logic [1:0] s_bresp, s_rresp, rs;
	logic [31:0] s_rdata;
	logic link_clk, rx_serial, word_valid, slip_rollover, rec_clk, pll_locked, dpa_locked, cal_busy;
	logic [9:0] rx_word;
	int n_fail = 0, checks_done = 0, cal_n = 0, ro_n = 0, rec_n = 0, k0;
	logic rec_d;
	always #20 clock = ~clock; // Fabric clock comes from the bench's own source
	// Pulse-width and toggle monitors, sampled on the core clock
	always @(posedge clock)
	begin
		cal_n <= cal_n + int'(cal_busy);
		ro_n <= ro_n + int'(slip_rollover);
		rec_d <= rec_clk;
		rec_n <= rec_n + int'(rec_clk != rec_d);
	end
	serial_rx_align_control #(.DESER_FACTOR(10)) u_serial_rx_align_control (.clock(clock),
		.rst_b(rst_b), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .link_clk(link_clk), .rx_serial(rx_serial),
		.rx_word(rx_word), .word_valid(word_valid), .slip_rollover(slip_rollover),
		.rec_clk(rec_clk), .pll_locked(pll_locked), .dpa_locked(dpa_locked), .cal_busy(cal_busy));
	serial_tx_model u_serial_tx_model (.run(run), .pattern(pat), .link_clk(link_clk),
		.rx_serial(rx_serial));
	task tally_and_finish;
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task timeout;
		n_fail++;
		$display("wrong value at %0t: wait ran out", $time);
		tally_and_finish;
	endtask : timeout
	// Write: address and data offered together, each released once taken
	task axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
		int b;
		logic aw_ok, w_ok, b_ok;
		b = 0;
		b_ok = 1'b0;
		@(posedge clock);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		// Handshakes are judged mid-cycle and acted on right after the edge that takes them
		while (!b_ok)
		begin
			@(negedge clock);
			aw_ok = s_awvalid & s_awready;
			w_ok = s_wvalid & s_wready;
			b_ok = s_bvalid & s_bready;
			rs = s_bresp;
			@(posedge clock);
			if (aw_ok)
				s_awvalid <= 1'b0;
			if (w_ok)
				s_wvalid <= 1'b0;
			if (++b > 200)
				timeout;
		end
		s_bready <= 1'b0;
		check(rs, exp);
	endtask : axi_write
	task axi_read(input logic [3:0] a);
		int b;
		@(posedge clock);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		b = 0;
		do
		begin
			@(negedge clock);
			b++;
		end
		while (s_arready !== 1'b1 && b < 100);
		@(posedge clock);
		s_arvalid <= 1'b0;
		s_rready <= 1'b1;
		do
		begin
			@(negedge clock);
			b++;
		end
		while (s_rvalid !== 1'b1 && b < 200);
		if (b >= 200)
			timeout;
		rd = s_rdata;
		rs = s_rresp;
		@(posedge clock);
		s_rready <= 1'b0;
	endtask : axi_read
	task wait_words(input int n);
		int b;
		repeat (n)
		begin
			b = 0;
			do
			begin
				@(negedge clock);
				b++;
			end
			while (word_valid !== 1'b1 && b < 2000);
			if (b >= 2000)
				timeout;
		end
	endtask : wait_words
	task wait_lock;
		int b;
		b = 0;
		do
		begin
			@(negedge clock);
			b++;
		end
		while (!(pll_locked === 1'b1 && dpa_locked === 1'b1) && b < 5000);
		if (b >= 5000)
			timeout;
	endtask : wait_lock
	// Control write held for a whole word period by time, since resets stop the words
	task pulse_ctrl(input logic [31:0] bits);
		axi_write(ctrl_addr, bits, resp_okay);
		repeat (word_cycles) @(negedge clock); // Held one parallel cycle
		axi_write(ctrl_addr, 32'h0, resp_okay);
		wait_words(2);
	endtask : pulse_ctrl
	function automatic int rot_idx(input logic [9:0] w);
		logic [19:0] two;
		two = {pat, pat};
		for (int k = 0; k < 10; k++)
			if (w === two[19 - k -: 10])
				return k;
		return -1;
	endfunction : rot_idx
	task read_slips(input logic [7:0] exp);
		axi_read(status_addr);
		check(rd[15:8], exp);
	endtask : read_slips
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		axi_read(config_addr);
		check(rd, 32'h0000_0a00);
		check(rs, resp_okay);
		axi_read(status_addr);
		check(rd & 32'hff07, 32'h0);
		axi_write(word_addr, 32'h0, resp_slverr);
		axi_write(config_addr, 32'h0000_0301, resp_okay); // Rollover 3, phase-aligned
		run <= 1'b1;
		wait_lock;
		wait_words(3);
		k0 = rot_idx(rx_word);
		check(k0 >= 0, 1);
		check(rec_clk, 1'b0);
		ro_n = 0;
		for (int i = 1; i <= 3; i++)
		begin
			pulse_ctrl(32'h1);
			check(rot_idx(rx_word), (k0 + i) % 10);
		end
		check(ro_n, word_cycles); // One parallel period
		read_slips(8'h0);
		pulse_ctrl(32'h1);
		read_slips(8'h1);
		pulse_ctrl(32'h10);
		read_slips(8'h0);
		// The boundary after a realign reset is wherever counting restarted
		k0 = rot_idx(rx_word);
		check(k0 >= 0, 1);
		pulse_ctrl(32'h1);
		check(rot_idx(rx_word), (k0 + 1) % 10);
		axi_write(ctrl_addr, 32'h2, resp_okay); // Freeze tracking
		wait_words(3);
		check(rot_idx(rx_word), (k0 + 1) % 10);
		axi_write(ctrl_addr, 32'h0, resp_okay);
		cal_n = 0;
		axi_write(ctrl_addr, 32'h20, resp_okay);
		wait_words(8);
		check(cal_n, cal_cycles);
		check({pll_locked, dpa_locked}, 2'b11);
		pulse_ctrl(32'h8); // Buffer flush after data corruption
		check(dpa_locked, 1'b1); // Not a loss-of-lock flag
		axi_write(ctrl_addr, 32'h4, resp_okay);
		repeat (word_cycles) @(negedge clock); // Held one parallel cycle
		check(dpa_locked, 1'b0);
		axi_write(ctrl_addr, 32'h0, resp_okay);
		wait_lock;
		axi_write(config_addr, 32'h0000_0302, resp_okay);
		wait_words(4);
		rec_n = 0;
		wait_words(4);
		check(rec_n > 0, 1);
		tally_and_finish;
	end
endmodule : test_serial_rx_align_control
